// file: hw/pmc_consts.svh
// Offsets, source and mode codes, frequency limits and timing counts of the power and clock control block
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH
`define PMC_OFS_SPLL 8'h00
`define PMC_OFS_UPLL 8'h04
`define PMC_OFS_PSTAT 8'h08
`define PMC_OFS_MAIN 8'h0C
`define PMC_OFS_CKOUT 8'h10
`define PMC_OFS_PWR 8'h14
`define PMC_OFS_STEN_LO 8'h18
`define PMC_OFS_STEN_HI 8'h1C
`define PMC_OFS_STPD_LO 8'h20
`define PMC_OFS_STPD_HI 8'h24
`define PMC_OFS_BOD 8'h28
`define PMC_OFS_RSTAT 8'h2C
`define PMC_SRC_IRC 2'h0
`define PMC_SRC_SYSOSC 2'h1
`define PMC_SRC_WDOSC 2'h2
`define PMC_SRC_MAIN 2'h3
`define PMC_SRC_PLL 2'h3
`define PMC_MODE_SLEEP 2'h1
`define PMC_MODE_DSLEEP 2'h2
`define PMC_MODE_DPD 2'h3
`define PMC_REF_MIN_MHZ 10
`define PMC_REF_MAX_MHZ 25
`define PMC_CCO_MIN_MHZ 156
`define PMC_CCO_MAX_MHZ 320
`define PMC_CLK_MHZ 100
`define PMC_CLK_NS 10
`define PMC_LOCK_US 100
`define PMC_LOCK_CYC (`PMC_LOCK_US * `PMC_CLK_MHZ)
`define PMC_WAKE_NS 50
`define PMC_WAKE_CYC (`PMC_WAKE_NS / `PMC_CLK_NS)
`define PMC_SW_GAP 3'h4
`define PMC_RST_HOLD 5'h10
`define PMC_START_PINS 40
`endif

// file: hw/pmc_pkg.sv
// Types of the power and clock control block
`default_nettype none
package pmc_pkg;
   typedef struct packed {
      logic use_pll;
      logic pwr;
      logic [1:0] psel;
      logic [4:0] msel;
   } pmc_pll_cfg_t;
   typedef enum logic [1:0] {PS_RUN, PS_SLEEP, PS_DSLEEP, PS_DPD} pmc_pwr_st_t;
   typedef enum logic [1:0] {SW_IDLE, SW_OFF, SW_ON} pmc_sw_st_t;
endpackage
`default_nettype wire

// file: hw/pmc_top.sv
// Clock synthesis control, clock selection, power modes, start logic, reset and brown-out
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.svh"
module pmc_top
   import pmc_pkg::*;
#(
   parameter int SYS_REF_MHZ = 12,
   parameter int USB_REF_MHZ = 12,
   parameter int unsigned LOCK_CYCLES = `PMC_LOCK_CYC
)(
   input wire logic CLOCK_I, // 100 MHz clock
   input wire logic RST_N_I, // Async reset, active low
   input wire logic [7:0] ADDR_I, // Register byte address
   input wire logic [31:0] WDATA_I, // Write data
   input wire logic WR_I, // Write strobe
   input wire logic RD_I, // Read strobe
   output logic [31:0] RDATA_O, // Read data, cycle after strobe
   input wire logic IRC_CLK_I, // RC oscillator level
   input wire logic SYSOSC_CLK_I, // System oscillator level
   input wire logic WDOSC_CLK_I, // Watchdog oscillator level
   input wire logic MAIN_CLK_I, // Main clock level
   input wire logic [`PMC_START_PINS-1:0] START_PIN_I, // Start logic pins
   input wire logic WAKE_PIN_N_I, // Deep power-down wake pin, active low
   input wire logic RESET_PIN_N_I, // External reset pin, active low
   input wire logic POR_I, // Power-on detect
   input wire logic WDT_RST_I, // Watchdog reset request
   input wire logic IRQ_I, // Any pending peripheral interrupt
   input wire logic [3:0] BOD_BELOW_I, // Supply below level n
   output logic [1:0] PLL_PWR_O, // Loop powered: 0 system, 1 USB
   output logic [1:0] PLL_SEL_O, // Loop output used, else bypass
   output logic [1:0] PLL_LOCK_O, // Loop locked
   output logic [3:0] MAIN_SRC_EN_O, // One-hot main clock gate, all gates off during a switch gap
   output logic CLKOUT_O, // Clock output pin
   output logic CORE_CLK_EN_O, // Core clock running
   output logic ANALOG_PD_O, // Analog blocks shut down
   output logic WDOSC_ON_O, // Watchdog oscillator running
   output logic BOD_ON_O, // Brown-out monitor running
   output logic DPD_O, // Deep power-down
   output logic IRC_EN_O, // RC oscillator enabled
   output logic CHIP_RST_O, // Chip reset
   output logic FLASH_INIT_O, // Flash controller init pulse
   output logic [`PMC_START_PINS-1:0] START_IRQ_O, // Start pin interrupts
   output logic BOD_IRQ_O // Brown-out interrupt
);
   localparam int NS = `PMC_START_PINS + 11;
   localparam int WAKE_FILT = `PMC_WAKE_CYC - 1;
   localparam int REF_MHZ [2] = '{SYS_REF_MHZ, USB_REF_MHZ};

   // -----------------------------------------
   // Input synchronisers
   // -----------------------------------------
   logic [NS-1:0] async_in;
   logic [NS-1:0] s1_q;
   logic [NS-1:0] s2_q;
   assign async_in = {BOD_BELOW_I, POR_I, RESET_PIN_N_I, WAKE_PIN_N_I, START_PIN_I,
                      MAIN_CLK_I, WDOSC_CLK_I, SYSOSC_CLK_I, IRC_CLK_I};
   for (genvar g = 0; g < NS; g++)
   begin : g_sync
      // Active-low pins reset to their idle level, so no false reset or wake follows reset
      localparam logic IDLE = g == `PMC_START_PINS + 4 || g == `PMC_START_PINS + 5;
      always_ff @(posedge CLOCK_I or negedge RST_N_I)
      begin
         if (!RST_N_I)
         begin
            s1_q[g] <= IDLE;
            s2_q[g] <= IDLE;
         end
         else
         begin
            s1_q[g] <= async_in[g];
            s2_q[g] <= s1_q[g];
         end
      end
   end
   wire [3:0] src_s = s2_q[3:0];
   wire [`PMC_START_PINS-1:0] start_s = s2_q[`PMC_START_PINS+3:4];
   wire wake_n_s = s2_q[`PMC_START_PINS+4];
   wire rstpin_n_s = s2_q[`PMC_START_PINS+5];
   wire por_s = s2_q[`PMC_START_PINS+6];
   wire [3:0] bod_s = s2_q[NS-1:NS-4];

   // -----------------------------------------
   // Registers and decode
   // -----------------------------------------
   pmc_pll_cfg_t pll_cfg_q [2];
   logic [1:0] pll_lock_q;
   logic [1:0] main_sel_q;
   logic [1:0] main_act_q;
   logic [3:0] src_en_q;
   logic [1:0] ckout_sel_q;
   logic keep_wd_q;
   logic keep_bod_q;
   logic [`PMC_START_PINS-1:0] start_en_q;
   logic [`PMC_START_PINS-1:0] start_pend_q;
   logic [`PMC_START_PINS-1:0] start_prev_q;
   logic [1:0] bod_irq_lvl_q;
   logic [1:0] bod_rst_lvl_q;
   logic bod_rst_en_q;
   logic bod_irq_q;
   logic [3:0] rst_cause_q;
   logic chip_rst_q;
   logic [4:0] rst_cnt_q;
   pmc_pwr_st_t pwr_st_q;
   logic [31:0] rdata_q;
   logic [31:0] rd_word;
   wire wr_spll = WR_I && ADDR_I == `PMC_OFS_SPLL;
   wire wr_upll = WR_I && ADDR_I == `PMC_OFS_UPLL;
   wire wr_main = WR_I && ADDR_I == `PMC_OFS_MAIN;
   wire wr_ckout = WR_I && ADDR_I == `PMC_OFS_CKOUT;
   wire wr_pwr = WR_I && ADDR_I == `PMC_OFS_PWR;
   wire wr_sten_lo = WR_I && ADDR_I == `PMC_OFS_STEN_LO;
   wire wr_sten_hi = WR_I && ADDR_I == `PMC_OFS_STEN_HI;
   wire wr_stpd_lo = WR_I && ADDR_I == `PMC_OFS_STPD_LO;
   wire wr_stpd_hi = WR_I && ADDR_I == `PMC_OFS_STPD_HI;
   wire wr_bod = WR_I && ADDR_I == `PMC_OFS_BOD;
   wire wr_rstat = WR_I && ADDR_I == `PMC_OFS_RSTAT;

   always_comb
   begin
      rd_word = 32'h0000_0000;
      if (ADDR_I == `PMC_OFS_SPLL) rd_word = {23'h00_0000, pll_cfg_q[0]};
      else if (ADDR_I == `PMC_OFS_UPLL) rd_word = {23'h00_0000, pll_cfg_q[1]};
      else if (ADDR_I == `PMC_OFS_PSTAT) rd_word = {30'h0000_0000, pll_lock_q};
      else if (ADDR_I == `PMC_OFS_MAIN) rd_word = {26'h000_0000, main_act_q, 2'h0, main_sel_q};
      else if (ADDR_I == `PMC_OFS_CKOUT) rd_word = {30'h0000_0000, ckout_sel_q};
      else if (ADDR_I == `PMC_OFS_PWR) rd_word = {26'h000_0000, pwr_st_q, keep_bod_q, keep_wd_q, 2'h0};
      else if (ADDR_I == `PMC_OFS_STEN_LO) rd_word = start_en_q[31:0];
      else if (ADDR_I == `PMC_OFS_STEN_HI) rd_word = {24'h00_0000, start_en_q[39:32]};
      else if (ADDR_I == `PMC_OFS_STPD_LO) rd_word = start_pend_q[31:0];
      else if (ADDR_I == `PMC_OFS_STPD_HI) rd_word = {24'h00_0000, start_pend_q[39:32]};
      else if (ADDR_I == `PMC_OFS_BOD) rd_word = {26'h000_0000, bod_irq_q, bod_rst_en_q, bod_rst_lvl_q, bod_irq_lvl_q};
      else if (ADDR_I == `PMC_OFS_RSTAT) rd_word = {28'h000_0000, rst_cause_q};
   end

   always_ff @(posedge CLOCK_I or negedge RST_N_I)
   begin
      if (!RST_N_I) rdata_q <= 32'h0000_0000;
      else if (RD_I) rdata_q <= rd_word;
      else rdata_q <= 32'h0000_0000;
   end

   // -----------------------------------------
   // Synthesis loops, system and USB
   // -----------------------------------------
   // Reference and oscillator range check; multiplier spans 1..32, ratio 2..16
   function automatic logic cfg_ok(input int ref_mhz, input pmc_pll_cfg_t c);
      int fout;
      int fcco;
      fout = ref_mhz * (int'(c.msel) + 1);
      fcco = fout * (2 << c.psel);
      return ref_mhz >= `PMC_REF_MIN_MHZ && ref_mhz <= `PMC_REF_MAX_MHZ &&
             fcco >= `PMC_CCO_MIN_MHZ && fcco <= `PMC_CCO_MAX_MHZ;
   endfunction

   logic [31:0] lock_cnt_q [2];
   logic [1:0] pll_ok;
   wire [1:0] pll_wr = {wr_upll, wr_spll};
   for (genvar p = 0; p < 2; p++)
   begin : g_pll
      assign pll_ok[p] = cfg_ok(REF_MHZ[p], pll_cfg_q[p]);
      always_ff @(posedge CLOCK_I or negedge RST_N_I)
      begin
         if (!RST_N_I)
         begin
            pll_cfg_q[p] <= '0;
            lock_cnt_q[p] <= 32'h0000_0000;
            pll_lock_q[p] <= 1'b0;
         end
         else if (chip_rst_q)
         begin
            pll_cfg_q[p] <= '0;
            lock_cnt_q[p] <= 32'h0000_0000;
            pll_lock_q[p] <= 1'b0;
         end
         else
         begin
            if (pll_wr[p]) pll_cfg_q[p] <= pmc_pll_cfg_t'(WDATA_I[8:0]);
            // Any rewrite of a loop restarts its settling
            if (pll_wr[p] || !pll_cfg_q[p].pwr || !pll_ok[p])
            begin
               lock_cnt_q[p] <= 32'h0000_0000;
               pll_lock_q[p] <= 1'b0;
            end
            else if (lock_cnt_q[p] == LOCK_CYCLES - 1) pll_lock_q[p] <= 1'b1;
            else lock_cnt_q[p] <= lock_cnt_q[p] + 32'h0000_0001;
         end
      end
      assign PLL_PWR_O[p] = pll_cfg_q[p].pwr;
      assign PLL_SEL_O[p] = pll_cfg_q[p].use_pll;
   end
   assign PLL_LOCK_O = pll_lock_q;

   // -----------------------------------------
   // Main clock switch and clock output
   // -----------------------------------------
   // Old gate closes, a gap lets both sources finish their phase, then new gate opens
   pmc_sw_st_t sw_st_q;
   logic [2:0] sw_cnt_q;
   logic ckout_q;
   always_ff @(posedge CLOCK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         main_sel_q <= `PMC_SRC_IRC;
         main_act_q <= `PMC_SRC_IRC;
         src_en_q <= 4'h1;
         sw_st_q <= SW_IDLE;
         sw_cnt_q <= 3'h0;
         ckout_sel_q <= `PMC_SRC_IRC;
         ckout_q <= 1'b0;
      end
      else if (chip_rst_q)
      begin
         main_sel_q <= `PMC_SRC_IRC;
         main_act_q <= `PMC_SRC_IRC;
         src_en_q <= 4'h1;
         sw_st_q <= SW_IDLE;
         sw_cnt_q <= 3'h0;
         ckout_sel_q <= `PMC_SRC_IRC;
         ckout_q <= 1'b0;
      end
      else
      begin
         if (wr_main) main_sel_q <= WDATA_I[1:0];
         if (wr_ckout) ckout_sel_q <= WDATA_I[1:0];
         ckout_q <= src_s[ckout_sel_q];
         case (sw_st_q)
            SW_IDLE:
               if (main_sel_q != main_act_q)
               begin
                  src_en_q <= 4'h0;
                  sw_cnt_q <= 3'h0;
                  sw_st_q <= SW_OFF;
               end
            SW_OFF:
               if (sw_cnt_q == `PMC_SW_GAP - 3'h1)
               begin
                  main_act_q <= main_sel_q;
                  sw_st_q <= SW_ON;
               end
               else sw_cnt_q <= sw_cnt_q + 3'h1;
            default:
            begin
               src_en_q <= 4'h1 << main_act_q;
               sw_st_q <= SW_IDLE;
            end
         endcase
      end
   end
   assign MAIN_SRC_EN_O = src_en_q;
   assign CLKOUT_O = ckout_q;

   // -----------------------------------------
   // Power modes, start logic, brown-out
   // -----------------------------------------
   logic core_en_q;
   logic analog_pd_q;
   logic wd_on_q;
   logic bod_on_q;
   logic dpd_q;
   logic [2:0] wake_cnt_q;
   logic [`PMC_START_PINS-1:0] start_rise;
   pmc_pwr_st_t pwr_st_d;
   wire [`PMC_START_PINS-1:0] wdata40 = {WDATA_I[7:0], WDATA_I};
   assign start_rise = start_s & ~start_prev_q & start_en_q;
   wire start_ev = |start_rise;
   wire dpd_wake = pwr_st_q == PS_DPD && !wake_n_s && wake_cnt_q == 3'(WAKE_FILT - 1);
   // A mode write carries its own keep bits, so they apply together with the new mode
   wire keep_wd_d = wr_pwr ? WDATA_I[2] : keep_wd_q;
   wire keep_bod_d = wr_pwr ? WDATA_I[3] : keep_bod_q;

   always_comb
   begin
      pwr_st_d = pwr_st_q;
      case (pwr_st_q)
         PS_RUN:
            if (wr_pwr && WDATA_I[1:0] == `PMC_MODE_SLEEP) pwr_st_d = PS_SLEEP;
            else if (wr_pwr && WDATA_I[1:0] == `PMC_MODE_DSLEEP) pwr_st_d = PS_DSLEEP;
            else if (wr_pwr && WDATA_I[1:0] == `PMC_MODE_DPD) pwr_st_d = PS_DPD;
         PS_SLEEP:
            if (IRQ_I || start_ev || bod_irq_q) pwr_st_d = PS_RUN;
         PS_DSLEEP:
            if (start_ev || (keep_bod_q && bod_irq_q)) pwr_st_d = PS_RUN;
         default:
            pwr_st_d = PS_DPD; // Left only by a chip reset, such as the one that the wake pin raises
      endcase
   end

   always_ff @(posedge CLOCK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         pwr_st_q <= PS_RUN;
         {core_en_q, analog_pd_q, wd_on_q, bod_on_q, dpd_q} <= 5'h16;
         {keep_wd_q, keep_bod_q} <= 2'h0;
         wake_cnt_q <= 3'h0;
         start_en_q <= '0;
         start_pend_q <= '0;
         start_prev_q <= '0;
         {bod_irq_lvl_q, bod_rst_lvl_q, bod_rst_en_q, bod_irq_q} <= 6'h00;
      end
      else if (chip_rst_q)
      begin
         pwr_st_q <= PS_RUN;
         {core_en_q, analog_pd_q, wd_on_q, bod_on_q, dpd_q} <= 5'h16;
         {keep_wd_q, keep_bod_q} <= 2'h0;
         wake_cnt_q <= 3'h0;
         start_en_q <= '0;
         start_pend_q <= '0;
         start_prev_q <= start_s;
         {bod_irq_lvl_q, bod_rst_lvl_q, bod_rst_en_q, bod_irq_q} <= 6'h00;
      end
      else
      begin
         pwr_st_q <= pwr_st_d;
         core_en_q <= pwr_st_d == PS_RUN;
         analog_pd_q <= pwr_st_d == PS_DSLEEP || pwr_st_d == PS_DPD;
         wd_on_q <= pwr_st_d == PS_RUN || pwr_st_d == PS_SLEEP || (pwr_st_d == PS_DSLEEP && keep_wd_d);
         bod_on_q <= pwr_st_d == PS_RUN || pwr_st_d == PS_SLEEP || (pwr_st_d == PS_DSLEEP && keep_bod_d);
         dpd_q <= pwr_st_d == PS_DPD;
         if (wr_pwr) {keep_bod_q, keep_wd_q} <= WDATA_I[3:2];
         wake_cnt_q <= (pwr_st_q == PS_DPD && !wake_n_s) ? wake_cnt_q + 3'h1 : 3'h0;
         start_prev_q <= start_s;
         if (wr_sten_lo) start_en_q[31:0] <= WDATA_I;
         if (wr_sten_hi) start_en_q[39:32] <= WDATA_I[7:0];
         // New edges win over a clear written in the same cycle
         start_pend_q <= (start_pend_q & ~(wr_stpd_lo ? {8'h00, WDATA_I} : '0)
                                       & ~(wr_stpd_hi ? {wdata40[7:0], 32'h0000_0000} : '0))
                         | start_rise;
         if (wr_bod) {bod_rst_en_q, bod_rst_lvl_q, bod_irq_lvl_q} <= WDATA_I[4:0];
         bod_irq_q <= bod_on_q && bod_s[bod_irq_lvl_q];
      end
   end
   assign CORE_CLK_EN_O = core_en_q;
   assign ANALOG_PD_O = analog_pd_q;
   assign WDOSC_ON_O = wd_on_q;
   assign BOD_ON_O = bod_on_q;
   assign DPD_O = dpd_q;
   assign START_IRQ_O = start_pend_q;
   assign BOD_IRQ_O = bod_irq_q;

   // -----------------------------------------
   // Chip reset sources
   // -----------------------------------------
   logic irc_en_q;
   logic flash_init_q;
   wire bod_rst = bod_rst_en_q && bod_on_q && bod_s[bod_rst_lvl_q];
   wire [3:0] rst_src = {bod_rst, WDT_RST_I, !rstpin_n_s, por_s};
   wire any_rst = |rst_src || dpd_wake;
   always_ff @(posedge CLOCK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         rst_cnt_q <= `PMC_RST_HOLD;
         chip_rst_q <= 1'b1;
         irc_en_q <= 1'b1;
         flash_init_q <= 1'b0;
         rst_cause_q <= 4'h1;
      end
      else
      begin
         if (any_rst) rst_cnt_q <= `PMC_RST_HOLD;
         else if (rst_cnt_q != 5'h00) rst_cnt_q <= rst_cnt_q - 5'h01;
         chip_rst_q <= any_rst || rst_cnt_q > 5'h01;
         irc_en_q <= any_rst || chip_rst_q || !analog_pd_q || core_en_q;
         flash_init_q <= any_rst && !chip_rst_q;
         // Cause bits are sticky; a new cause wins over a clear
         rst_cause_q <= (rst_cause_q & ~(wr_rstat ? WDATA_I[3:0] : 4'h0)) | rst_src;
      end
   end
   assign CHIP_RST_O = chip_rst_q;
   assign IRC_EN_O = irc_en_q;
   assign FLASH_INIT_O = flash_init_q;
   assign RDATA_O = rdata_q;

   // -----------------------------------------
   // Assertions
   // -----------------------------------------
   pll_lock_valid_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      pll_lock_q[0] |-> pll_cfg_q[0].pwr && pll_ok[0] && lock_cnt_q[0] == LOCK_CYCLES - 1)
      else $error("loop locked without valid powered settling");
   pll_off_reset_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      $fell(chip_rst_q) |-> PLL_PWR_O == 2'h0 && PLL_SEL_O == 2'h0 && pll_lock_q == 2'h0)
      else $error("loop not off and bypassed after reset");
   switch_gap_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      $changed(src_en_q) && src_en_q != 4'h0 && !$past(chip_rst_q) |-> $past(src_en_q, 1) == 4'h0
         && $past(src_en_q, 5) == 4'h0)
      else $error("main clock gate changed without a gap");
   irc_reset_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      $fell(chip_rst_q) |-> main_act_q == `PMC_SRC_IRC && src_en_q == 4'h1 && irc_en_q)
      else $error("not on RC oscillator after reset");
   sleep_wake_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      pwr_st_q == PS_SLEEP && IRQ_I && !any_rst |=> core_en_q && pwr_st_q == PS_RUN)
      else $error("sleep did not resume on interrupt");
   deep_analog_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      pwr_st_q == PS_DSLEEP |-> analog_pd_q && !core_en_q && wd_on_q == keep_wd_q)
      else $error("deep-sleep power state wrong");
   dpd_wake_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (pwr_st_q == PS_DPD && !wake_n_s) [*4] |-> ##[0:1] chip_rst_q)
      else $error("wake pin pulse did not wake");
   start_pend_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      start_rise[0] && !chip_rst_q |=> START_IRQ_O[0])
      else $error("start pin edge lost");
   bod_irq_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      bod_on_q && bod_s[bod_irq_lvl_q] && !chip_rst_q && !wr_bod |=> BOD_IRQ_O)
      else $error("brown-out interrupt missing");
   wdt_reset_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      WDT_RST_I |=> chip_rst_q && irc_en_q && rst_cause_q[2])
      else $error("watchdog reset not applied");
endmodule // pmc_top
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking testbench of the power and clock control block
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.svh"
module tb_top;
   localparam int unsigned LK = 20;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [3:0] src = 4'h0;
   logic [39:0] start = 40'h00_0000_0000;
   logic wake_n = 1'b1;
   logic pin_n = 1'b1;
   logic por = 1'b0;
   logic wdt = 1'b0;
   logic irq = 1'b0;
   logic [3:0] below = 4'h0;
   logic [31:0] rdata, r;
   logic [1:0] pll_pwr, pll_sel, pll_lock;
   logic [3:0] src_en;
   logic clkout, core_en, ana_pd, wd_on, bod_on, dpd, irc_en, chip_rst, flash_init, bod_irq;
   logic [39:0] start_irq;
   int bad_count = 0;
   int samples_checked = 0;
   pmc_top #(.LOCK_CYCLES(LK)) DUT (.CLOCK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRC_CLK_I(src[0]), .SYSOSC_CLK_I(src[1]), .WDOSC_CLK_I(src[2]),
      .MAIN_CLK_I(src[3]), .START_PIN_I(start), .WAKE_PIN_N_I(wake_n), .RESET_PIN_N_I(pin_n), .POR_I(por),
      .WDT_RST_I(wdt), .IRQ_I(irq), .BOD_BELOW_I(below), .PLL_PWR_O(pll_pwr), .PLL_SEL_O(pll_sel),
      .PLL_LOCK_O(pll_lock), .MAIN_SRC_EN_O(src_en), .CLKOUT_O(clkout), .CORE_CLK_EN_O(core_en),
      .ANALOG_PD_O(ana_pd), .WDOSC_ON_O(wd_on), .BOD_ON_O(bod_on), .DPD_O(dpd), .IRC_EN_O(irc_en),
      .CHIP_RST_O(chip_rst), .FLASH_INIT_O(flash_init), .START_IRQ_O(start_irq), .BOD_IRQ_O(bod_irq));
   always #5 clk = ~clk;
   // ------------------------------------------------------------
   // Bus cycles and comparison
   // ------------------------------------------------------------
   task chk(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [7:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 r = rdata;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task give_verdict();
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Source s is held eleven cycles, long enough to pass every synchroniser and the wake filter
   task reset_seq(input int s, input logic [3:0] cause);
      int i;
      logic f, h;
      f = 1'b0;
      h = 1'b0;
      @(posedge clk);
      case (s)
         0: wdt <= 1'b1;
         1: pin_n <= 1'b0;
         2: below <= 4'h8;
         3: wake_n <= 1'b0;
         4: por <= 1'b1;
         default: ;
      endcase
      for (i = 0; i < 80; i++)
      begin
         @(posedge clk);
         if (i == 10)
         begin
            wdt <= 1'b0;
            pin_n <= 1'b1;
            below <= 4'h0;
            wake_n <= 1'b1;
            por <= 1'b0;
         end
         #1;
         if (flash_init === 1'b1) f = 1'b1;
         if (chip_rst === 1'b1) h = 1'b1;
         else if (h && i > 10) break;
      end
      if (s != 5) chk(f, 1'b1);
      chk({h, chip_rst, irc_en}, 3'h5);
      chk(src_en, 4'h1);
      chk({pll_pwr, pll_sel}, 4'h0);
      chk({core_en, dpd}, 2'h2);
      rd_reg(`PMC_OFS_RSTAT);
      chk(r[3:0], cause);
      wr_reg(`PMC_OFS_RSTAT, 32'h0000_000F);
   endtask
   task t_main(input logic [1:0] s, input logic [3:0] onehot);
      wr_reg(`PMC_OFS_MAIN, {30'h0000_0000, s});
      cyc(2);
      chk(src_en, 4'h0);
      cyc(6);
      chk(src_en, onehot);
      rd_reg(`PMC_OFS_MAIN);
      chk(r[5:4], s);
   endtask
   task t_pll();
      wr_reg(`PMC_OFS_SPLL, 32'h0000_00A7);
      cyc(LK + 5);
      chk(pll_lock[0], 1'b0);
      wr_reg(`PMC_OFS_SPLL, 32'h0000_00A5);
      cyc(LK - 1);
      chk(pll_lock[0], 1'b0);
      cyc(4);
      chk(pll_lock[0], 1'b1);
      wr_reg(`PMC_OFS_UPLL, 32'h0000_00E0);
      cyc(LK + 3);
      chk(pll_lock, 2'h3);
      wr_reg(`PMC_OFS_UPLL, 32'h0000_00A3);
      cyc(LK + 3);
      chk({pll_pwr, pll_lock}, 4'hF);
      rd_reg(`PMC_OFS_PSTAT);
      chk(r[1:0], 2'h3);
      wr_reg(`PMC_OFS_SPLL, 32'h0000_01A5);
      cyc(LK + 3);
      chk(pll_sel, 2'h1);
      t_main(2'h3, 4'h8);
      t_main(2'h0, 4'h1);
   endtask
   task t_modes();
      for (int k = 0; k < 4; k++)
      begin
         wr_reg(`PMC_OFS_CKOUT, k);
         src <= 4'h1 << k;
         cyc(5);
         chk(clkout, 1'b1);
         @(posedge clk);
         src <= ~(4'h1 << k);
         cyc(5);
         chk(clkout, 1'b0);
      end
      wr_reg(`PMC_OFS_PWR, 32'h0000_0001);
      cyc(2);
      chk(core_en, 1'b0);
      @(posedge clk);
      irq <= 1'b1;
      cyc(3);
      chk(core_en, 1'b1);
      @(posedge clk);
      irq <= 1'b0;
      wr_reg(`PMC_OFS_STEN_LO, 32'h0000_0001);
      // Main clock is still on the RC oscillator here, and the watchdog oscillator is kept
      wr_reg(`PMC_OFS_PWR, 32'h0000_0006);
      cyc(2);
      chk({core_en, ana_pd, wd_on, bod_on}, 4'h6);
      @(posedge clk);
      start <= 40'h00_0000_0001;
      cyc(8);
      chk({core_en, ana_pd, start_irq}, {2'h2, 40'h00_0000_0001});
      @(posedge clk);
      start <= 40'h00_0000_0000;
      wr_reg(`PMC_OFS_STPD_LO, 32'h0000_0001);
      cyc(2);
      chk(start_irq, 40'h00_0000_0000);
      wr_reg(`PMC_OFS_BOD, 32'h0000_0002);
      below <= 4'h4;
      cyc(6);
      chk(bod_irq, 1'b1);
      rd_reg(`PMC_OFS_BOD);
      chk(r[5], 1'b1);
      @(posedge clk);
      below <= 4'h0;
      cyc(6);
      chk(bod_irq, 1'b0);
      rd_reg(8'h40);
      chk(r, 32'h0000_0000);
   endtask
   task t_bod_rst();
      wr_reg(`PMC_OFS_BOD, 32'h0000_001C);
      reset_seq(2, 4'h8);
   endtask
   task t_dpd();
      wr_reg(`PMC_OFS_PWR, 32'h0000_0003);
      cyc(2);
      chk({dpd, irc_en}, 2'h2);
      reset_seq(3, 4'h0);
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      reset_seq(5, 4'h1);
      t_pll();
      reset_seq(0, 4'h4);
      t_modes();
      reset_seq(1, 4'h2);
      t_bod_rst();
      reset_seq(4, 4'h1);
      t_dpd();
      give_verdict();
   end
   initial
   begin
      #100000;
      bad_count++;
      give_verdict();
   end
endmodule // tb_top
`default_nettype wire
